/* rpc_map.svh */
`ifndef RPC_MAP_SVH
`define RPC_MAP_SVH

// clock and timing
`define RPC_CLK_MHZ 100
`define RPC_LF_HZ 32000
`define RPC_LF_DIV ((`RPC_CLK_MHZ * 1000000) / `RPC_LF_HZ)
`define RPC_RST_MIN_US 1500
`define RPC_RST_MAX_US 4000
`define RPC_RST_MIN_CYC (`RPC_RST_MIN_US * `RPC_CLK_MHZ)
`define RPC_RST_MAX_CYC (`RPC_RST_MAX_US * `RPC_CLK_MHZ)
`define RPC_BREAK_TICKS 4
`define RPC_WDOG_HOLD_CYC 16

// register byte offsets
`define RPC_OFS_CTRL 8'h00
`define RPC_OFS_WDOG_LOAD 8'h04
`define RPC_OFS_WDOG_KICK 8'h08
`define RPC_OFS_DIR 8'h0C
`define RPC_OFS_OUT 8'h10
`define RPC_OFS_PD_STRONG 8'h14
`define RPC_OFS_IRQ_SEL 8'h18
`define RPC_OFS_WAKE_EN 8'h1C
`define RPC_OFS_STATUS 8'h20
`define RPC_OFS_MASK 8'h24
`define RPC_OFS_PIN_IN 8'h28
`define RPC_OFS_CAUSE 8'h2C
`define RPC_OFS_KEY 8'h30

// control fields
`define RPC_CTRL_CLKREQ_EN 0
`define RPC_CTRL_CLKREQ_SEL 1
`define RPC_CTRL_WDOG_EN 2
`define RPC_CTRL_W 3
`define RPC_CLOCK_REQUEST_ENABLE_KEY 32'h0000_0246

// clock request lines
`define RPC_CLKREQ_LINE_A 6
`define RPC_CLKREQ_LINE_B 2

// reset values
`define RPC_CTRL_RST 3'h0
`define RPC_WDOG_LOAD_RST 32'h00FF_FFFF

`endif

/* rpc_pkg.sv */
package rpc_pkg;
    typedef enum logic {
        RPC_ST_HOLD,
        RPC_ST_RUN
    } rpc_state_e;

    typedef struct packed {
        logic wdog;
        logic brk;
        logic por;
        logic pin;
    } rpc_cause_s;
endpackage : rpc_pkg

/* rpc_filt_if.sv */
interface rpc_filt_if;
    logic tick;
    logic raw;
    logic active;

    modport filt (input tick, input raw, output active);
    modport user (output tick, output raw, input active);
endinterface : rpc_filt_if

/* rpc_glitch_filter.sv */
module rpc_glitch_filter import rpc_pkg::*; #(
    parameter int TICKS = 4
) (
    input wire logic clock,
    input wire logic reset_n,
    rpc_filt_if.filt f
);
    localparam int CW = $clog2(TICKS + 1);
    localparam logic [CW-1:0] FULL = CW'(TICKS);

    logic [CW-1:0] cnt_ff;
    logic active_ff;

    // counts slow ticks; any inactive sample restarts, so glitches never reach full
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= '0;
        end else if (!f.raw) begin
            cnt_ff <= '0;
        end else if (f.tick && cnt_ff != FULL) begin
            cnt_ff <= cnt_ff + CW'(1);
        end
    end

    // release is immediate once the input goes inactive
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            active_ff <= 1'b0;
        end else begin
            active_ff <= f.raw && f.tick && (cnt_ff == FULL - CW'(1) || cnt_ff == FULL) ||
                         f.raw && active_ff;
        end
    end

    assign f.active = active_ff;
endmodule : rpc_glitch_filter

/* rpc_reset_pio_ctrl.sv */
// The implementer's own choices: the address map and the strobed register port.
`include "rpc_map.svh"

module rpc_reset_pio_ctrl import rpc_pkg::*; #(
    parameter int N_PIO = 16,
    parameter int LF_DIV = `RPC_LF_DIV,
    parameter int RST_MIN_CYC = `RPC_RST_MIN_CYC,
    parameter int RST_MAX_CYC = `RPC_RST_MAX_CYC,
    parameter int BREAK_TICKS = `RPC_BREAK_TICKS
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic external_reset_pin_n,
    input wire logic power_low,
    input wire logic uart_rx,
    input wire logic deep_sleep,
    input wire logic clock_needed,
    input wire logic [N_PIO-1:0] programmable_io_line_in,
    output logic [N_PIO-1:0] programmable_io_line_out,
    output logic [N_PIO-1:0] programmable_io_line_oe_n,
    output logic [N_PIO-1:0] programmable_io_line_pd_strong,
    output logic [N_PIO-1:0] programmable_io_line_pd_weak,
    output logic sys_reset_n,
    output logic wake_req,
    output logic irq
);
    // extra tick covers the phase of the first sample against the tick
    localparam int FILT_TICKS = (RST_MIN_CYC + LF_DIV - 1) / LF_DIV + 1;
    localparam int DW = $clog2(LF_DIV);
    localparam logic [DW-1:0] DIV_LAST = DW'(LF_DIV - 1);
    localparam int HW = $clog2(`RPC_WDOG_HOLD_CYC + 1);
    localparam logic [HW-1:0] HOLD_LOAD = HW'(`RPC_WDOG_HOLD_CYC);
    localparam logic [N_PIO-1:0] LINE_A = N_PIO'(1) << `RPC_CLKREQ_LINE_A;
    localparam logic [N_PIO-1:0] LINE_B = N_PIO'(1) << `RPC_CLKREQ_LINE_B;

    rpc_filt_if pin_if ();
    rpc_filt_if brk_if ();

    logic [DW-1:0] lf_div_ff;
    logic lf_tick_ff;
    logic [`RPC_CTRL_W-1:0] ctrl_ff;
    logic [31:0] wdog_load_ff;
    logic [31:0] wdog_cnt_ff;
    logic [HW-1:0] wdog_hold_ff;
    logic [N_PIO-1:0] dir_ff;
    logic [N_PIO-1:0] out_ff;
    logic [N_PIO-1:0] strong_ff;
    logic [N_PIO-1:0] irq_sel_ff;
    logic [N_PIO-1:0] wake_en_ff;
    logic [N_PIO-1:0] status_ff;
    logic [N_PIO-1:0] mask_ff;
    logic [N_PIO-1:0] pio_in_q_ff;
    rpc_cause_s cause_ff;
    rpc_state_e state_ff;
    logic sys_reset_n_ff;
    logic [N_PIO-1:0] pio_out_ff;
    logic [N_PIO-1:0] pio_oe_n_ff;
    logic [N_PIO-1:0] pd_strong_ff;
    logic [N_PIO-1:0] pd_weak_ff;
    logic wake_ff;
    logic irq_ff;
    logic [31:0] rdata_ff;

    logic wdog_fire;
    logic wdog_active;
    logic rst_req;
    logic [N_PIO-1:0] pio_rise;
    logic [N_PIO-1:0] clkreq_mask;
    logic clkreq_level;
    logic [N_PIO-1:0] nxt_out;
    logic [N_PIO-1:0] nxt_oe_n;
    logic [31:0] nxt_rdata;
    rpc_cause_s src_now;

    // slow oscillator stand-in: one tick every LF_DIV clocks
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lf_div_ff <= '0;
            lf_tick_ff <= 1'b0;
        end else begin
            lf_div_ff <= (lf_div_ff == DIV_LAST) ? '0 : lf_div_ff + DW'(1);
            lf_tick_ff <= (lf_div_ff == DIV_LAST);
        end
    end

    assign pin_if.tick = lf_tick_ff;
    assign pin_if.raw = !external_reset_pin_n;
    assign brk_if.tick = lf_tick_ff;
    assign brk_if.raw = !uart_rx;

    rpc_glitch_filter #(.TICKS(FILT_TICKS)) u_pin_filt (
        .clock(clock),
        .reset_n(reset_n),
        .f(pin_if.filt)
    );

    // a line held low for several slow ticks is taken as a break character
    rpc_glitch_filter #(.TICKS(BREAK_TICKS)) u_brk_filt (
        .clock(clock),
        .reset_n(reset_n),
        .f(brk_if.filt)
    );

    // watchdog: reload on kick, fire when it runs out, then stretch the reset
    assign wdog_fire = ctrl_ff[`RPC_CTRL_WDOG_EN] && wdog_cnt_ff == 32'h0000_0000;
    assign wdog_active = wdog_fire || wdog_hold_ff != '0;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wdog_cnt_ff <= `RPC_WDOG_LOAD_RST;
        end else if (rst_req || !ctrl_ff[`RPC_CTRL_WDOG_EN]) begin
            wdog_cnt_ff <= wdog_load_ff;
        end else if (reg_wr && reg_addr == `RPC_OFS_WDOG_KICK) begin
            wdog_cnt_ff <= wdog_load_ff;
        end else if (wdog_cnt_ff != 32'h0000_0000) begin
            wdog_cnt_ff <= wdog_cnt_ff - 32'h0000_0001;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wdog_hold_ff <= '0;
        end else if (wdog_fire) begin
            wdog_hold_ff <= HOLD_LOAD;
        end else if (wdog_hold_ff != '0) begin
            wdog_hold_ff <= wdog_hold_ff - HW'(1);
        end
    end

    // any one source keeps the device in reset
    always_comb begin
        src_now.pin = pin_if.active;
        src_now.por = power_low;
        src_now.brk = brk_if.active;
        src_now.wdog = wdog_active;
    end
    assign rst_req = |src_now;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= RPC_ST_HOLD;
            sys_reset_n_ff <= 1'b0;
        end else begin
            state_ff <= rst_req ? RPC_ST_HOLD : RPC_ST_RUN;
            sys_reset_n_ff <= !rst_req;
        end
    end

    // reset cause survives the device reset; write one to clear, a new cause wins
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cause_ff <= '0;
        end else begin
            cause_ff <= (cause_ff & ~((reg_wr && reg_addr == `RPC_OFS_CAUSE) ? reg_wdata[3:0] : 4'h0))
                        | src_now;
        end
    end

    // configuration, returned to its defaults by every device reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= `RPC_CTRL_RST;
            wdog_load_ff <= `RPC_WDOG_LOAD_RST;
            dir_ff <= '0;
            out_ff <= '0;
            strong_ff <= '0;
            irq_sel_ff <= '0;
            wake_en_ff <= '0;
            mask_ff <= '0;
        end else if (rst_req) begin
            ctrl_ff <= `RPC_CTRL_RST;
            wdog_load_ff <= `RPC_WDOG_LOAD_RST;
            dir_ff <= '0;
            out_ff <= '0;
            strong_ff <= '0;
            irq_sel_ff <= '0;
            wake_en_ff <= '0;
            mask_ff <= '0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `RPC_OFS_CTRL: ctrl_ff <= reg_wdata[`RPC_CTRL_W-1:0];
                `RPC_OFS_WDOG_LOAD: wdog_load_ff <= reg_wdata;
                `RPC_OFS_DIR: dir_ff <= reg_wdata[N_PIO-1:0];
                `RPC_OFS_OUT: out_ff <= reg_wdata[N_PIO-1:0];
                `RPC_OFS_PD_STRONG: strong_ff <= reg_wdata[N_PIO-1:0];
                `RPC_OFS_IRQ_SEL: irq_sel_ff <= reg_wdata[N_PIO-1:0];
                `RPC_OFS_WAKE_EN: wake_en_ff <= reg_wdata[N_PIO-1:0];
                `RPC_OFS_MASK: mask_ff <= reg_wdata[N_PIO-1:0];
                default: ;
            endcase
        end
    end

    // interrupt events: rising edge on a selected line; set wins over clear
    assign pio_rise = programmable_io_line_in & ~pio_in_q_ff;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pio_in_q_ff <= '0;
            status_ff <= '0;
        end else begin
            pio_in_q_ff <= programmable_io_line_in;
            if (rst_req) begin
                status_ff <= '0;
            end else begin
                status_ff <= (status_ff & ~((reg_wr && reg_addr == `RPC_OFS_STATUS) ? reg_wdata[N_PIO-1:0] : '0))
                             | (pio_rise & irq_sel_ff);
            end
        end
    end

    // clock request takes over the chosen line as an output
    assign clkreq_mask = !ctrl_ff[`RPC_CTRL_CLKREQ_EN] ? '0 :
                         ctrl_ff[`RPC_CTRL_CLKREQ_SEL] ? LINE_B : LINE_A;
    assign clkreq_level = clock_needed && !deep_sleep;

    always_comb begin
        nxt_out = (out_ff & ~clkreq_mask) | (clkreq_level ? clkreq_mask : '0);
        nxt_oe_n = ~(dir_ff | clkreq_mask);
        if (rst_req) begin
            nxt_out = '0;
            nxt_oe_n = '1;
        end
    end

    // pull-downs stay weak in reset; the strong choice only counts in run
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pio_out_ff <= '0;
            pio_oe_n_ff <= '1;
            pd_strong_ff <= '0;
            pd_weak_ff <= '1;
        end else begin
            pio_out_ff <= nxt_out;
            pio_oe_n_ff <= nxt_oe_n;
            pd_strong_ff <= rst_req ? '0 : strong_ff;
            pd_weak_ff <= rst_req ? '1 : ~strong_ff;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wake_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            wake_ff <= !rst_req && deep_sleep && |(programmable_io_line_in & wake_en_ff);
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (reg_addr)
            `RPC_OFS_CTRL: nxt_rdata = 32'(ctrl_ff);
            `RPC_OFS_WDOG_LOAD: nxt_rdata = wdog_load_ff;
            `RPC_OFS_WDOG_KICK: nxt_rdata = wdog_cnt_ff;
            `RPC_OFS_DIR: nxt_rdata = 32'(dir_ff);
            `RPC_OFS_OUT: nxt_rdata = 32'(out_ff);
            `RPC_OFS_PD_STRONG: nxt_rdata = 32'(strong_ff);
            `RPC_OFS_IRQ_SEL: nxt_rdata = 32'(irq_sel_ff);
            `RPC_OFS_WAKE_EN: nxt_rdata = 32'(wake_en_ff);
            `RPC_OFS_STATUS: nxt_rdata = 32'(status_ff);
            `RPC_OFS_MASK: nxt_rdata = 32'(mask_ff);
            `RPC_OFS_PIN_IN: nxt_rdata = 32'(programmable_io_line_in);
            `RPC_OFS_CAUSE: nxt_rdata = 32'(cause_ff);
            `RPC_OFS_KEY: nxt_rdata = `RPC_CLOCK_REQUEST_ENABLE_KEY;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_ff;
    assign sys_reset_n = sys_reset_n_ff;
    assign programmable_io_line_out = pio_out_ff;
    assign programmable_io_line_oe_n = pio_oe_n_ff;
    assign programmable_io_line_pd_strong = pd_strong_ff;
    assign programmable_io_line_pd_weak = pd_weak_ff;
    assign wake_req = wake_ff;
    assign irq = irq_ff;

    // helper: how long the pin has been held low without a break
    logic [31:0] low_cnt_ff;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt_ff <= 32'h0000_0000;
        end else begin
            low_cnt_ff <= external_reset_pin_n ? 32'h0000_0000 : low_cnt_ff + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    power_reset_a: assert property (power_low |=> !sys_reset_n_ff)
        else $error("power-on source did not reset");
    break_reset_a: assert property (brk_if.active |=> !sys_reset_n_ff)
        else $error("uart break did not reset");
    pin_filter_a: assert property ($rose(pin_if.active) |-> !external_reset_pin_n)
        else $error("pin filter fired with pin high");
    reset_min_a: assert property ($rose(pin_if.active) |-> low_cnt_ff >= 32'(RST_MIN_CYC))
        else $error("pin reset came too early");
    reset_max_a: assert property (low_cnt_ff >= 32'(RST_MAX_CYC - 1) |-> pin_if.active)
        else $error("pin reset came too late");
    pins_float_a: assert property (!sys_reset_n_ff |-> (&pio_oe_n_ff && &pd_weak_ff))
        else $error("pin driven during reset");
    reset_defaults_a: assert property ($rose(sys_reset_n_ff) |-> (dir_ff == '0 && strong_ff == '0))
        else $error("io not input weak pull-down after reset");
    strong_pd_a: assert property ((reg_wr && reg_addr == `RPC_OFS_PD_STRONG && !rst_req) ##1 !rst_req
        |=> pd_strong_ff == $past(reg_wdata[N_PIO-1:0], 2))
        else $error("strong pull-down write not applied");
    pio_irq_a: assert property ((!rst_req && |(pio_rise & irq_sel_ff & mask_ff)) ##1 !rst_req |=> irq_ff)
        else $error("io event did not raise interrupt");
    clkreq_low_a: assert property ((ctrl_ff[`RPC_CTRL_CLKREQ_EN] && !ctrl_ff[`RPC_CTRL_CLKREQ_SEL]
        && deep_sleep && !rst_req) |=> (!pio_out_ff[`RPC_CLKREQ_LINE_A] && !pio_oe_n_ff[`RPC_CLKREQ_LINE_A]))
        else $error("clock request not low in deep sleep");
    hold_release_a: assert property ((power_low || pin_if.active || brk_if.active || wdog_hold_ff != '0)
        |=> (state_ff == RPC_ST_HOLD && !sys_reset_n_ff))
        else $error("reset released with a source active");
endmodule : rpc_reset_pio_ctrl

/* rpc_host_model.sv */
module rpc_host_model (
    input wire logic clock,
    input wire logic clock_request,
    output logic external_reset_pin_n,
    output logic ext_clock_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_cnt;
    initial external_reset_pin_n = 1'b1;
    // the board holds the pin low for a number of cycles, then lets go
    task automatic press(input int cyc);
        @(posedge clock);
        external_reset_pin_n <= 1'b0;
        repeat (cyc) @(posedge clock);
        external_reset_pin_n <= 1'b1;
    endtask : press
    // slow source: the clock shows up well after the request, still in time
    always_ff @(posedge clock) begin
        if (!clock_request) begin
            wait_cnt <= 0;
            ext_clock_ok <= 1'b0;
        end else if (wait_cnt < 40) begin
            wait_cnt <= wait_cnt + 1;
        end else begin
            ext_clock_ok <= 1'b1;
        end
    end
endmodule : rpc_host_model

/* test_reset_and_pio_control.sv */
module test_reset_and_pio_control;
    import rpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LFD = 10;
    localparam int RMIN = 50;
    localparam int RMAX = 200;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic w;
        logic [31:0] e;
    } rpc_row_s;
    logic clock, reset_n, reg_wr, reg_rd, power_low, uart_rx, deep_sleep, clock_needed;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic [15:0] pin_drive, io_in, io_out, io_oe_n, pd_strong, pd_weak;
    logic sys_reset_n, wake_req, irq, rst_pin_n, clk_ok, clk_req;
    int errors, compares, cycles, n;
    rpc_row_s rows[10] = '{
        '{8'h0C, 32'hFFFF_FFFF, 1'b1, 32'h0000_FFFF},
        '{8'h0C, 32'h0000_0030, 1'b1, 32'h0000_0030},
        '{8'h10, 32'h0000_1234, 1'b1, 32'h0000_1234},
        '{8'h14, 32'h0000_00A5, 1'b1, 32'h0000_00A5},
        '{8'h18, 32'h0000_0F0F, 1'b1, 32'h0000_0F0F},
        '{8'h1C, 32'h0000_0010, 1'b1, 32'h0000_0010},
        '{8'h24, 32'h0000_0008, 1'b1, 32'h0000_0008},
        '{8'h30, 32'h0000_0000, 1'b0, 32'h0000_0246},
        '{8'h3C, 32'h0000_FFFF, 1'b1, 32'h0000_0000},
        '{8'h00, 32'h0000_0000, 1'b1, 32'h0000_0000}};
    // pins read back what the device drives, else what the board drives
    assign io_in = (~io_oe_n & io_out) | (io_oe_n & pin_drive);
    assign clk_req = (io_out[6] & ~io_oe_n[6]) | (io_out[2] & ~io_oe_n[2]);
    rpc_reset_pio_ctrl #(.N_PIO(16), .LF_DIV(LFD), .RST_MIN_CYC(RMIN), .RST_MAX_CYC(RMAX),
        .BREAK_TICKS(2)) u_dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_reset_pin_n(rst_pin_n), .power_low(power_low), .uart_rx(uart_rx),
        .deep_sleep(deep_sleep), .clock_needed(clock_needed), .programmable_io_line_in(io_in),
        .programmable_io_line_out(io_out), .programmable_io_line_oe_n(io_oe_n),
        .programmable_io_line_pd_strong(pd_strong), .programmable_io_line_pd_weak(pd_weak),
        .sys_reset_n(sys_reset_n), .wake_req(wake_req), .irq(irq));
    rpc_host_model u_host (.clock(clock), .clock_request(clk_req),
        .external_reset_pin_n(rst_pin_n), .ext_clock_ok(clk_ok));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic wrap_up;
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    // the whole run is about 800 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd
    task automatic tick(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask : tick
    task automatic wait_rst(input logic lvl, input int lim);
        n = 0;
        while (sys_reset_n !== lvl && n < lim) begin
            @(posedge clock);
            #1 n++;
        end
    endtask : wait_rst
    initial begin
        {reg_wr, reg_rd, power_low, deep_sleep, clock_needed} = '0;
        {reg_addr, reg_wdata, pin_drive} = '0;
        uart_rx = 1'b1;
        reset_n = 1'b0;
        repeat (3) @(posedge clock);
        #1 chk({sys_reset_n, io_oe_n}, {1'b0, 16'hFFFF});
        chk(pd_strong, 16'h0);
        chk({pd_weak, io_out}, {16'hFFFF, 16'h0});
        @(posedge clock);
        reset_n <= 1'b1;
        tick(2);
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk(rd_val, rows[i].e);
        end
        chk({pd_strong, io_oe_n}, {16'h00A5, 16'hFFCF});
        // interrupt: raise, mask, unmask, clear
        @(posedge clock) pin_drive[3] <= 1'b1;
        tick(3);
        chk(irq, 1'b1);
        wr(8'h24, 32'h0);
        tick(2);
        chk(irq, 1'b0);
        wr(8'h24, 32'h8);
        wr(8'h20, 32'h8);
        tick(2);
        chk(irq, 1'b0);
        rd(8'h20);
        chk(rd_val, 32'h0);
        @(posedge clock) deep_sleep <= 1'b1;
        pin_drive[4] <= 1'b1;
        tick(3);
        chk(wake_req, 1'b1);
        // clock request on line 6, then on line 2
        wr(8'h00, 32'h1);
        tick(2);
        chk({io_oe_n[6], io_out[6]}, 2'b00);
        @(posedge clock) deep_sleep <= 1'b0;
        clock_needed <= 1'b1;
        tick(2);
        chk({io_oe_n[6], io_out[6]}, 2'b01);
        chk(wake_req, 1'b0);
        n = 0;
        while (clk_ok !== 1'b1 && n < RMAX) begin
            @(posedge clock);
            #1 n++;
        end
        chk(clk_ok, 1'b1);
        wr(8'h00, 32'h3);
        tick(2);
        chk({io_oe_n[2], io_out[2]}, 2'b01);
        @(posedge clock) deep_sleep <= 1'b1;
        tick(2);
        chk(io_out[2], 1'b0);
        // power detector: config lost, writes during reset lost
        @(posedge clock) power_low <= 1'b1;
        tick(2);
        chk({sys_reset_n, io_oe_n}, {1'b0, 16'hFFFF});
        wr(8'h0C, 32'hFFFF);
        tick(20);
        chk(sys_reset_n, 1'b0);
        @(posedge clock) power_low <= 1'b0;
        wait_rst(1'b1, 5);
        chk({sys_reset_n, pd_weak}, {1'b1, 16'hFFFF});
        chk(pd_strong, 16'h0);
        rd(8'h0C);
        chk(rd_val, 32'h0);
        rd(8'h2C);
        chk(rd_val, 32'h2);
        wr(8'h2C, 32'hF);
        // short glitch on the pin must be swallowed
        u_host.press(3);
        wait_rst(1'b0, RMAX + 50);
        chk(sys_reset_n, 1'b1);
        fork
            u_host.press(300);
        join_none
        wait_rst(1'b0, RMAX + 50);
        chk((n >= RMIN) && (n <= RMIN + 2 * LFD + 4), 1'b1);
        tick(100);
        chk(sys_reset_n, 1'b0);
        wait_rst(1'b1, 300);
        chk(sys_reset_n, 1'b1);
        rd(8'h2C);
        chk(rd_val, 32'h1);
        wr(8'h2C, 32'hF);
        @(posedge clock) uart_rx <= 1'b0;
        wait_rst(1'b0, 45);
        chk(sys_reset_n, 1'b0);
        @(posedge clock) uart_rx <= 1'b1;
        wait_rst(1'b1, 100);
        rd(8'h2C);
        chk(rd_val, 32'h4);
        wr(8'h2C, 32'hF);
        // watchdog with a short load value
        wr(8'h04, 32'd20);
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h4);
        wait_rst(1'b0, 60);
        chk(sys_reset_n, 1'b0);
        wait_rst(1'b1, 40);
        chk((n >= 15) && (n <= 18), 1'b1);
        rd(8'h2C);
        chk(rd_val, 32'h8);
        rd(8'h00);
        chk(rd_val, 32'h0);
        // power reset in mid-run: config and the sticky reset cause both go back to zero
        wr(8'h0C, 32'h0000_00FF);
        @(posedge clock) reset_n <= 1'b0;
        tick(1);
        chk({sys_reset_n, io_oe_n}, {1'b0, 16'hFFFF});
        chk({pd_weak, io_out}, {16'hFFFF, 16'h0});
        @(posedge clock) reset_n <= 1'b1;
        tick(2);
        chk({sys_reset_n, io_oe_n}, {1'b1, 16'hFFFF});
        rd(8'h2C);
        chk(rd_val, 32'h0);
        wrap_up();
    end
endmodule : test_reset_and_pio_control
